// *** pkg/accflg_pkg.sv ***
// Package for the accumulator and ALU status flag block.
// Assumes a single core clock and Avalon-MM register access with 32-bit words.
package accflg_pkg;
    // Register byte offsets
    localparam logic [7:0] ACCFLG_STATUS_OFS = 8'h86;
    localparam logic [7:0] ACCFLG_ACC_OFS = 8'h00;
    localparam logic [7:0] ACCFLG_CMD_OFS = 8'h04;
    // Flag bit positions in the status register
    localparam int ACCFLG_CARRY_BIT = 2;
    localparam int ACCFLG_NIBBLE_BIT = 1;
    localparam int ACCFLG_ZERO_BIT = 0;
    // Reset values
    localparam logic [2:0] ACCFLG_STATUS_RST = 3'h0;
    localparam logic [7:0] ACCFLG_ACC_RST = 8'h00;
    // Command register fields: opcode in [3:0], operand in [15:8]
    localparam int ACCFLG_CMD_OP_LSB = 0;
    localparam int ACCFLG_CMD_DATA_LSB = 8;
    // Operations of the ALU
    typedef enum logic [3:0] {
        ACCFLG_OP_LOAD = 4'h0,
        ACCFLG_OP_ADD = 4'h1,
        ACCFLG_OP_SUB = 4'h2,
        ACCFLG_OP_AND = 4'h3,
        ACCFLG_OP_OR = 4'h4,
        ACCFLG_OP_XOR = 4'h5,
        ACCFLG_OP_RLC = 4'h6,
        ACCFLG_OP_RRC = 4'h7,
        ACCFLG_OP_CMP = 4'h8,
        ACCFLG_OP_XCH = 4'h9,
        ACCFLG_OP_TEST = 4'ha,
        ACCFLG_OP_LOADQ = 4'hb
    } accflg_op_t;
    // Flag triple
    typedef struct packed {
        logic carry;
        logic nibble;
        logic zero;
    } accflg_flags_t;
    // ALU result with flag update enables
    typedef struct packed {
        logic [7:0] value;
        logic writeAcc;
        logic updCarry;
        logic updNibble;
        logic updZero;
        accflg_flags_t flags;
    } accflg_result_t;
endpackage : accflg_pkg

// *** rtl/accflg_alu.sv ***
// Combinational ALU computing a result and carry, nibble-carry and zero flags.
// Assumes the caller registers the result and applies the update enables.
`timescale 1ns/1ps
module accflg_alu (
    input accflg_pkg::accflg_op_t op,
    input wire logic [7:0] accIn,
    input wire logic [7:0] operand,
    input wire logic carryIn,
    output accflg_pkg::accflg_result_t res
);
    logic [8:0] sum;
    logic [4:0] low;

    // Operation decode and flag derivation
    always_comb begin
        res = '0;
        sum = 9'h000;
        low = 5'h00;
        case (op)
            accflg_pkg::ACCFLG_OP_ADD: begin
                sum = {1'b0, accIn} + {1'b0, operand};
                low = {1'b0, accIn[3:0]} + {1'b0, operand[3:0]};
                res.value = sum[7:0];
                res.writeAcc = 1'b1;
                res.flags.carry = sum[8];
                res.flags.nibble = low[4];
                res.updCarry = 1'b1;
                res.updNibble = 1'b1;
                res.updZero = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_SUB, accflg_pkg::ACCFLG_OP_CMP: begin
                sum = {1'b0, accIn} - {1'b0, operand};
                low = {1'b0, accIn[3:0]} - {1'b0, operand[3:0]};
                res.value = sum[7:0];
                res.writeAcc = (op == accflg_pkg::ACCFLG_OP_SUB);
                res.flags.carry = ~sum[8];
                res.flags.nibble = ~low[4];
                res.updCarry = 1'b1;
                res.updNibble = (op == accflg_pkg::ACCFLG_OP_SUB);
                res.updZero = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_AND, accflg_pkg::ACCFLG_OP_OR,
            accflg_pkg::ACCFLG_OP_XOR, accflg_pkg::ACCFLG_OP_TEST: begin
                case (op)
                    accflg_pkg::ACCFLG_OP_AND: res.value = accIn & operand;
                    accflg_pkg::ACCFLG_OP_OR: res.value = accIn | operand;
                    accflg_pkg::ACCFLG_OP_XOR: res.value = accIn ^ operand;
                    default: res.value = operand;
                endcase
                res.writeAcc = (op != accflg_pkg::ACCFLG_OP_TEST);
                res.updZero = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_RLC: begin
                res.value = {accIn[6:0], carryIn};
                res.writeAcc = 1'b1;
                res.flags.carry = accIn[7];
                res.updCarry = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_RRC: begin
                res.value = {carryIn, accIn[7:1]};
                res.writeAcc = 1'b1;
                res.flags.carry = accIn[0];
                res.updCarry = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_LOAD: begin
                res.value = operand;
                res.writeAcc = 1'b1;
                res.updZero = 1'b1;
            end
            accflg_pkg::ACCFLG_OP_XCH, accflg_pkg::ACCFLG_OP_LOADQ: begin
                res.value = operand;
                res.writeAcc = 1'b1;
            end
            default: res = '0;
        endcase
        res.flags.zero = (res.value == 8'h00);
    end
endmodule : accflg_alu

// *** rtl/accflg_top.sv ***
// Accumulator and ALU status flags with an Avalon-MM register slave.
// Assumes ref_clk at 100 MHz and an asynchronous active-low reset rst_b.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module accflg_top (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic aluValid,
    input wire logic [3:0] aluOp,
    input wire logic [7:0] memOperand,
    output logic [7:0] working_accumulator,
    output logic [7:0] accToMem,
    output logic accToMemValid
);
    logic rstSync1_reg;
    logic rstSync2_reg;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    accflg_pkg::accflg_flags_t alu_status_flags_reg;
    accflg_pkg::accflg_flags_t flags_next;
    logic [7:0] accToMem_reg;
    logic accToMemValid_reg;
    logic [31:0] readData_reg;
    logic ack_reg;
    logic busReq;
    logic busWr;
    logic swCmd;
    accflg_pkg::accflg_op_t curOp;
    logic [7:0] curOperand;
    logic doOp;
    accflg_pkg::accflg_result_t aluRes;

    // Bus access helper: match an exact byte offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // Reset release synchroniser
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end

    // One wait cycle, then acknowledge
    assign busReq = (avs_read | avs_write) & ~ack_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign busWr = avs_write & ack_reg & avs_byteenable[0];
    assign swCmd = busWr & hit(avs_address, accflg_pkg::ACCFLG_CMD_OFS);

    always_ff @(posedge ref_clk or negedge rstSync2_reg) begin
        if (!rstSync2_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= busReq;
        end
    end

    // Operation source: core port has priority over software command
    assign doOp = aluValid | swCmd;
    assign curOp = accflg_pkg::accflg_op_t'(aluValid ? aluOp :
        avs_writedata[accflg_pkg::ACCFLG_CMD_OP_LSB +: 4]);
    assign curOperand = aluValid ? memOperand :
        avs_writedata[accflg_pkg::ACCFLG_CMD_DATA_LSB +: 8];

    accflg_alu accflg_alu_inst (
        .op(curOp),
        .accIn(acc_reg),
        .operand(curOperand),
        .carryIn(alu_status_flags_reg.carry),
        .res(aluRes)
    );

    // Accumulator next value; only ALU and its own bus word reach it
    always_comb begin
        acc_next = acc_reg;
        if (doOp && aluRes.writeAcc) begin
            acc_next = aluRes.value;
        end else if (busWr && hit(avs_address, accflg_pkg::ACCFLG_ACC_OFS)) begin
            acc_next = avs_writedata[7:0];
        end
    end

    // Flag next value; an ALU flag update wins over a software write in the same cycle
    always_comb begin
        flags_next = alu_status_flags_reg;
        if (busWr && hit(avs_address, accflg_pkg::ACCFLG_STATUS_OFS)) begin
            // All three flags are read-write, so bit set and clear work here
            flags_next.carry = avs_writedata[accflg_pkg::ACCFLG_CARRY_BIT];
            flags_next.nibble = avs_writedata[accflg_pkg::ACCFLG_NIBBLE_BIT];
            flags_next.zero = avs_writedata[accflg_pkg::ACCFLG_ZERO_BIT];
        end
        if (doOp) begin
            if (aluRes.updCarry) flags_next.carry = aluRes.flags.carry;
            if (aluRes.updNibble) flags_next.nibble = aluRes.flags.nibble;
            if (aluRes.updZero) flags_next.zero = aluRes.flags.zero;
        end
    end

    // Accumulator and flags; nothing is saved on interrupt entry
    always_ff @(posedge ref_clk or negedge rstSync2_reg) begin
        if (!rstSync2_reg) begin
            acc_reg <= accflg_pkg::ACCFLG_ACC_RST;
            alu_status_flags_reg <= accflg_pkg::ACCFLG_STATUS_RST;
        end else begin
            acc_reg <= acc_next;
            alu_status_flags_reg <= flags_next;
        end
    end

    // Old accumulator goes back to memory on exchange
    always_ff @(posedge ref_clk or negedge rstSync2_reg) begin
        if (!rstSync2_reg) begin
            accToMem_reg <= 8'h00;
            accToMemValid_reg <= 1'b0;
        end else begin
            accToMemValid_reg <= doOp && (curOp == accflg_pkg::ACCFLG_OP_XCH);
            if (doOp && curOp == accflg_pkg::ACCFLG_OP_XCH) begin
                accToMem_reg <= acc_reg;
            end
        end
    end

    // Read data; unused status bits read zero
    always_ff @(posedge ref_clk or negedge rstSync2_reg) begin
        if (!rstSync2_reg) begin
            readData_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            if (hit(avs_address, accflg_pkg::ACCFLG_STATUS_OFS)) begin
                readData_reg <= {29'h0000_0000, alu_status_flags_reg};
            end else if (hit(avs_address, accflg_pkg::ACCFLG_ACC_OFS)) begin
                readData_reg <= {24'h00_0000, acc_reg};
            end else begin
                readData_reg <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata = readData_reg;
    assign working_accumulator = acc_reg;
    assign accToMem = accToMem_reg;
    assign accToMemValid = accToMemValid_reg;
endmodule : accflg_top

// *** sim/accflg_assertions.sv ***
// Port checker of the accumulator and flag block.
// Assumes binding to accflg_top; sees only its ports.
`timescale 1ns/1ps
module accflg_assertions (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic aluValid,
    input wire logic [3:0] aluOp,
    input wire logic [7:0] memOperand,
    input wire logic [7:0] working_accumulator,
    input wire logic [7:0] accToMem,
    input wire logic accToMemValid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic req;
    logic done;
    // Bus request and read completion
    assign req = avs_read || avs_write;
    assign done = avs_read && !avs_waitrequest;
    AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait");
    AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("long wait");
    AST_STATUS_HI: assert property (done && avs_address == 8'h86 |->
        avs_readdata[31:3] == 29'h0) else $error("status upper bits set");
    AST_UNMAPPED: assert property (done && !(avs_address inside {8'h00, 8'h04, 8'h86}) |->
        avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_XCH: assert property (aluValid && aluOp == 4'h9 |=> accToMemValid &&
        accToMem == $past(working_accumulator)) else $error("exchange output wrong");
    AST_XCH_ONLY: assert property (!(aluValid && aluOp == 4'h9) && !avs_write |=>
        !accToMemValid)
        else $error("stray exchange pulse");
    AST_ADD: assert property (aluValid && aluOp == 4'h1 |=> working_accumulator ==
        $past(working_accumulator) + $past(memOperand)) else $error("add result wrong");
    AST_LOADQ: assert property (aluValid && aluOp == 4'hb |=>
        working_accumulator == $past(memOperand)) else $error("quiet load wrong");
    AST_CMP_KEEP: assert property (aluValid && aluOp == 4'h8 |=>
        $stable(working_accumulator)) else $error("compare wrote acc");
    AST_HOLD: assert property (!aluValid && !avs_write |=>
        $stable(working_accumulator)) else $error("acc changed idle");
    // Main scenarios
    cover property (done && avs_address == 8'h86);
    cover property (accToMemValid);
    cover property (aluValid && aluOp == 4'h8);
endmodule : accflg_assertions
bind accflg_top accflg_assertions accflg_assertions_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .aluValid(aluValid),
    .aluOp(aluOp), .memOperand(memOperand), .working_accumulator(working_accumulator),
    .accToMem(accToMem), .accToMemValid(accToMemValid));

// *** sim/test_accumulator_and_alu_flags.sv ***
// Self-checking bench of the accumulator and flag block.
// Assumes accflg_top with one wait state per bus access.
`timescale 1ns/1ps
module test_accumulator_and_alu_flags;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic aluValid = 1'b0;
    logic [3:0] aluOp = 4'h0;
    logic [7:0] memOperand = 8'h00;
    logic [7:0] working_accumulator;
    logic [7:0] accToMem;
    logic accToMemValid;
    logic [31:0] rd;
    int n_mismatch = 0;
    int n_checks = 0;
    // Clock of 10 ns
    always #5 ref_clk = ~ref_clk;
    accflg_top accflg_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .aluValid(aluValid), .aluOp(aluOp),
        .memOperand(memOperand), .working_accumulator(working_accumulator),
        .accToMem(accToMem), .accToMemValid(accToMemValid));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    // One bus access, held until waitrequest is low
    task automatic bus(logic wr, logic [7:0] a, logic [15:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {16'h0, d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Core operation, then acc and flag check; acc[8] skips the acc check
    task automatic alu(logic [3:0] op, logic [7:0] d, logic [8:0] acc, logic [2:0] flg);
        logic [7:0] old;
        @(posedge ref_clk);
        old = working_accumulator;
        aluValid <= 1'b1;
        aluOp <= op;
        memOperand <= d;
        @(posedge ref_clk);
        aluValid <= 1'b0;
        memOperand <= ~d;
        @(negedge ref_clk);
        compare("pulse", {31'h0, op == 4'h9}, {31'h0, accToMemValid});
        if (op == 4'h9) compare("old acc", {24'h0, old}, {24'h0, accToMem});
        if (!acc[8]) compare("acc", {24'h0, acc[7:0]}, {24'h0, working_accumulator});
        bus(1'b0, 8'h86, 16'h0);
        compare("flags", {29'h0, flg}, rd);
    endtask : alu
    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, 8'h86, 16'h0);
        compare("status rst", 32'h0, rd);
        bus(1'b1, 8'h86, 16'h0007);
        bus(1'b0, 8'h86, 16'h0);
        compare("status wr", 32'h7, rd);
        bus(1'b1, 8'h86, 16'h0002);
        bus(1'b0, 8'h86, 16'h0);
        bus(1'b1, 8'h86, rd[15:0] | 16'h0004);
        bus(1'b0, 8'h86, 16'h0);
        compare("bit set", 32'h6, rd);
        bus(1'b1, 8'h86, 16'h0);
        alu(4'h0, 8'h00, 9'h000, 3'h1);
        alu(4'h0, 8'h8f, 9'h08f, 3'h0);
        alu(4'h1, 8'h71, 9'h000, 3'h7);
        alu(4'h1, 8'h05, 9'h005, 3'h0);
        alu(4'h2, 8'h06, 9'h0ff, 3'h0);
        alu(4'h2, 8'h0f, 9'h0f0, 3'h6);
        alu(4'h5, 8'hf0, 9'h000, 3'h7);
        alu(4'h4, 8'h81, 9'h081, 3'h6);
        bus(1'b1, 8'h86, 16'h0);
        alu(4'h7, 8'h00, 9'h040, 3'h4);
        alu(4'h3, 8'h00, 9'h000, 3'h5);
        alu(4'h6, 8'h00, 9'h001, 3'h1);
        alu(4'h0, 8'h40, 9'h040, 3'h0);
        alu(4'h8, 8'h40, 9'h040, 3'h5);
        alu(4'h8, 8'h41, 9'h040, 3'h0);
        bus(1'b1, 8'h86, 16'h0007);
        alu(4'h9, 8'h3c, 9'h03c, 3'h7);
        alu(4'hb, 8'h5a, 9'h05a, 3'h7);
        bus(1'b1, 8'h86, 16'h0);
        alu(4'ha, 8'h00, 9'h05a, 3'h1);
        bus(1'b1, 8'h04, 16'h0501);
        bus(1'b0, 8'h00, 16'h0);
        compare("acc reg", 32'h5f, rd);
        bus(1'b1, 8'h10, 16'h00ff);
        bus(1'b0, 8'h10, 16'h0);
        compare("unmapped", 32'h0, rd);
        bus(1'b0, 8'h86, 16'h0);
        compare("cmd flags", 32'h0, rd);
        summarize();
    end
endmodule : test_accumulator_and_alu_flags
